// [logic/mac_measurement_arming_control.sv]
`default_nettype none
module mac_measurement_arming_control #(
  parameter int unsigned CYC_PER_MS = mac_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extArm,
  input wire logic startChannelEvent,
  input wire logic stopChannelEvent,
  output logic startArm,
  output logic stopArm,
  output logic totalizeGate,
  output logic resultValid,
  output logic measureBusy
);
  localparam int unsigned DCW = mac_pkg::DCW;
  localparam int unsigned ECW = mac_pkg::ECW;
  localparam int unsigned TW = mac_pkg::TW;
  localparam int unsigned GW = mac_pkg::GW;
  typedef struct packed {
    mac_pkg::mac_ctrl_t ctrl;
    logic [ECW-1:0] startCount;
    logic [TW-1:0] startTicks;
    logic [ECW-1:0] stopCount;
    logic [TW-1:0] stopTime;
    logic stopLong;
    logic [GW-1:0] gateMs;
    logic busy;
    logic startSeen;
    logic stopSeen;
    logic gate;
    logic valid;
    logic badCombo;
    logic cancel;
    logic tiStartGo;
    logic tiStopGo;
    logic totStartGo;
    logic totStopGo;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic extMeta;
    logic extSync;
    logic extPrev;
    logic startEvMeta;
    logic startEvSync;
    logic startEvPrev;
    logic stopEvMeta;
    logic stopEvSync;
    logic stopEvPrev;
  } mac_state_t;
  mac_state_t s_reg;
  mac_state_t s_next;
  logic extRise;
  logic extFall;
  logic startEvPulse;
  logic stopEvPulse;
  logic tiStartFire;
  logic tiStopFire;
  logic totStartFire;
  logic totStopFire;
  logic isInterval;
  logic [DCW-1:0] startDelayCyc;
  logic [DCW-1:0] stopDelayCyc;
  logic [DCW-1:0] gateCyc;
  mac_pkg::mac_delay_t tiStartMode;
  mac_pkg::mac_delay_t tiStopMode;
  mac_pkg::mac_delay_t totStopMode;
  logic access;
  logic commit;
  logic wrOk;
  logic mapped;
  logic comboOk;
  logic haltChains;
  logic [31:0] rdata;
  mac_pkg::mac_ctrl_t wrCtrl;
  // 100 ns is not a whole number of cycles, so the least time is rounded up
  function automatic logic [DCW-1:0] ticksToCycles(input logic [TW-1:0] t);
    ticksToCycles = (DCW'(t) * DCW'(mac_pkg::TICK_NS) + DCW'(mac_pkg::CLK_PERIOD_NS - 1))
                    / DCW'(mac_pkg::CLK_PERIOD_NS);
  endfunction
  function automatic logic inRange(input logic [31:0] v, input int unsigned lo, input int unsigned hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction
  assign extRise = s_reg.extSync && !s_reg.extPrev;
  assign extFall = !s_reg.extSync && s_reg.extPrev;
  assign startEvPulse = s_reg.startEvSync && !s_reg.startEvPrev;
  assign stopEvPulse = s_reg.stopEvSync && !s_reg.stopEvPrev;
  assign isInterval = s_reg.ctrl.func == mac_pkg::FN_INTERVAL;
  assign startDelayCyc = ticksToCycles(s_reg.startTicks);
  // long range counts whole milliseconds
  assign stopDelayCyc = s_reg.stopLong ? DCW'(s_reg.stopTime) * DCW'(CYC_PER_MS)
                                       : ticksToCycles(s_reg.stopTime);
  assign gateCyc = DCW'(s_reg.gateMs) * DCW'(CYC_PER_MS);
  // rise, fall, duty and width ignore the inner layers
  assign tiStartMode = isInterval ? s_reg.ctrl.startDelay : mac_pkg::DLY_NONE;
  assign tiStopMode = isInterval ? s_reg.ctrl.stopDelay : mac_pkg::DLY_NONE;
  assign totStopMode = (s_reg.ctrl.totStopSrc == mac_pkg::TSTOP_TIMED) ? mac_pkg::DLY_TIME
                                                                       : mac_pkg::DLY_NONE;
  assign comboOk = (s_reg.ctrl.totStopSrc == mac_pkg::TSTOP_TIMED) ||
                   (s_reg.ctrl.totStartExt == (s_reg.ctrl.totStopSrc == mac_pkg::TSTOP_EXT));
  assign access = psel && penable;
  assign commit = access && s_reg.pready;
  // halt the chains in the abort cycle itself, so no arm leaks out once busy has fallen
  assign haltChains = s_reg.cancel || (commit && pwrite && (paddr == mac_pkg::OFS_CMD) &&
                      (pwdata[mac_pkg::CMD_ABORT] || pwdata[mac_pkg::CMD_CFG_RESET]));
  assign wrCtrl = mac_pkg::mac_ctrl_t'(pwdata[mac_pkg::CTRL_W-1:0]);
  always_comb begin
    mapped = 1'b1;
    wrOk = 1'b1;
    rdata = 32'h00000000;
    case (paddr)
      mac_pkg::OFS_CTRL: begin
        rdata = {{(32-mac_pkg::CTRL_W){1'b0}}, s_reg.ctrl};
        wrOk = (wrCtrl.startDelay != 2'h3) && (wrCtrl.stopDelay != 2'h3) &&
               (wrCtrl.func != 2'h3) && (wrCtrl.totStopSrc != 2'h3);
      end
      mac_pkg::OFS_CMD: rdata = 32'h00000000;
      mac_pkg::OFS_START_COUNT: begin
        rdata = {{(32-ECW){1'b0}}, s_reg.startCount};
        wrOk = inRange(pwdata, mac_pkg::EVT_MIN, mac_pkg::EVT_MAX);
      end
      mac_pkg::OFS_START_TIME: begin
        rdata = {{(32-TW){1'b0}}, s_reg.startTicks};
        wrOk = inRange(pwdata, mac_pkg::TICK_MIN, mac_pkg::TICK_MAX);
      end
      mac_pkg::OFS_STOP_COUNT: begin
        rdata = {{(32-ECW){1'b0}}, s_reg.stopCount};
        wrOk = inRange(pwdata, mac_pkg::EVT_MIN, mac_pkg::EVT_MAX);
      end
      mac_pkg::OFS_STOP_TIME: begin
        rdata = {s_reg.stopLong, {(31-TW){1'b0}}, s_reg.stopTime};
        if (pwdata[mac_pkg::STOP_LONG_BIT]) begin
          wrOk = inRange({1'b0, pwdata[30:0]}, mac_pkg::LONG_MIN_MS, mac_pkg::LONG_MAX_MS);
        end else begin
          wrOk = inRange(pwdata, mac_pkg::TICK_MIN, mac_pkg::TICK_MAX);
        end
      end
      mac_pkg::OFS_GATE_TIME: begin
        rdata = {{(32-GW){1'b0}}, s_reg.gateMs};
        wrOk = inRange(pwdata, mac_pkg::GATE_MIN_MS, mac_pkg::GATE_MAX_MS);
      end
      mac_pkg::OFS_STATUS: begin
        rdata = {{(32-mac_pkg::STATUS_W){1'b0}}, s_reg.badCombo, s_reg.valid, s_reg.gate,
                 s_reg.stopSeen, s_reg.startSeen, s_reg.busy};
        wrOk = 1'b0;
      end
      default: begin
        mapped = 1'b0;
        wrOk = 1'b0;
      end
    endcase
  end
  always_comb begin
    s_next = s_reg;
    s_next.extMeta = extArm;
    s_next.extSync = s_reg.extMeta;
    s_next.extPrev = s_reg.extSync;
    s_next.startEvMeta = startChannelEvent;
    s_next.startEvSync = s_reg.startEvMeta;
    s_next.startEvPrev = s_reg.startEvSync;
    s_next.stopEvMeta = stopChannelEvent;
    s_next.stopEvSync = s_reg.stopEvMeta;
    s_next.stopEvPrev = s_reg.stopEvSync;
    s_next.cancel = 1'b0;
    s_next.tiStartGo = 1'b0;
    s_next.tiStopGo = 1'b0;
    s_next.totStartGo = 1'b0;
    s_next.totStopGo = 1'b0;
    // one wait state: the answer is prepared, then pready rises
    s_next.pready = 1'b0;
    if (access && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !mapped || (pwrite && !wrOk);
      s_next.prdata = pwrite ? 32'h00000000 : rdata;
    end
    // arm chain progress
    if (tiStartFire) begin
      s_next.startSeen = 1'b1;
      s_next.tiStopGo = 1'b1;
    end
    if (tiStopFire) begin
      s_next.stopSeen = 1'b1;
      s_next.busy = 1'b0;
    end
    if (totStartFire) begin
      s_next.gate = 1'b1;
      s_next.totStopGo = s_reg.ctrl.totStopSrc != mac_pkg::TSTOP_NOW;
    end
    if (totStopFire) begin
      s_next.gate = 1'b0;
      s_next.valid = 1'b1;
      s_next.busy = 1'b0;
    end
    if (commit && pwrite && wrOk) begin
      case (paddr)
        mac_pkg::OFS_CTRL: if (!s_reg.busy) s_next.ctrl = wrCtrl;
        mac_pkg::OFS_START_COUNT: s_next.startCount = pwdata[ECW-1:0];
        mac_pkg::OFS_START_TIME: s_next.startTicks = pwdata[TW-1:0];
        mac_pkg::OFS_STOP_COUNT: s_next.stopCount = pwdata[ECW-1:0];
        mac_pkg::OFS_STOP_TIME: begin
          s_next.stopLong = pwdata[mac_pkg::STOP_LONG_BIT];
          s_next.stopTime = pwdata[TW-1:0];
        end
        mac_pkg::OFS_GATE_TIME: s_next.gateMs = pwdata[GW-1:0];
        mac_pkg::OFS_CMD: begin
          if (pwdata[mac_pkg::CMD_INITIATE] && !s_reg.busy) begin
            if (s_reg.ctrl.func != mac_pkg::FN_TOTALIZE) begin
              s_next.busy = 1'b1;
              s_next.startSeen = 1'b0;
              s_next.stopSeen = 1'b0;
              s_next.tiStartGo = 1'b1;
            end else if (comboOk) begin
              s_next.busy = 1'b1;
              s_next.valid = 1'b0;
              s_next.badCombo = 1'b0;
              s_next.totStartGo = 1'b1;
            end else begin
              s_next.badCombo = 1'b1;
            end
          end
          // abort ends a free-running totalize; the count then becomes valid
          if (pwdata[mac_pkg::CMD_ABORT] || pwdata[mac_pkg::CMD_CFG_RESET]) begin
            s_next.cancel = 1'b1;
            s_next.busy = 1'b0;
            s_next.gate = 1'b0;
            s_next.tiStopGo = 1'b0;
            s_next.totStopGo = 1'b0;
            s_next.valid = s_reg.valid || s_reg.gate;
          end
          if (pwdata[mac_pkg::CMD_CFG_RESET]) begin
            s_next.ctrl = mac_pkg::CTRL_RESET;
            s_next.startCount = mac_pkg::RST_EVT;
            s_next.startTicks = mac_pkg::RST_TICKS;
            s_next.stopCount = mac_pkg::RST_EVT;
            s_next.stopTime = mac_pkg::RST_TICKS;
            s_next.stopLong = 1'b0;
            s_next.gateMs = mac_pkg::RST_GATE_MS;
          end
        end
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.ctrl <= mac_pkg::CTRL_RESET;
      s_reg.startCount <= mac_pkg::RST_EVT;
      s_reg.startTicks <= mac_pkg::RST_TICKS;
      s_reg.stopCount <= mac_pkg::RST_EVT;
      s_reg.stopTime <= mac_pkg::RST_TICKS;
      s_reg.gateMs <= mac_pkg::RST_GATE_MS;
    end else begin
      s_reg <= s_next;
    end
  end
  mac_arm_chain #(.DCW(DCW), .ECW(ECW)) startArmChain (
    .clk(clk),
    .reset(reset),
    .go(s_reg.tiStartGo),
    .cancel(haltChains),
    .useExt(s_reg.ctrl.startExt),
    .fallEdge(s_reg.ctrl.startFall),
    .extRise(extRise),
    .extFall(extFall),
    .delayMode(tiStartMode),
    .delayCycles(startDelayCyc),
    .eventTarget(s_reg.startCount),
    .eventPulse(startEvPulse),
    .fire(tiStartFire)
  );
  mac_arm_chain #(.DCW(DCW), .ECW(ECW)) stopArmChain (
    .clk(clk),
    .reset(reset),
    .go(s_reg.tiStopGo),
    .cancel(haltChains),
    .useExt(s_reg.ctrl.stopExt),
    .fallEdge(s_reg.ctrl.stopFall),
    .extRise(extRise),
    .extFall(extFall),
    .delayMode(tiStopMode),
    .delayCycles(stopDelayCyc),
    .eventTarget(s_reg.stopCount),
    .eventPulse(stopEvPulse),
    .fire(tiStopFire)
  );
  mac_arm_chain #(.DCW(DCW), .ECW(ECW)) totStartChain (
    .clk(clk),
    .reset(reset),
    .go(s_reg.totStartGo),
    .cancel(haltChains),
    .useExt(s_reg.ctrl.totStartExt),
    .fallEdge(s_reg.ctrl.totStartFall),
    .extRise(extRise),
    .extFall(extFall),
    .delayMode(mac_pkg::DLY_NONE),
    .delayCycles(gateCyc),
    .eventTarget(s_reg.startCount),
    .eventPulse(1'b0),
    .fire(totStartFire)
  );
  mac_arm_chain #(.DCW(DCW), .ECW(ECW)) totStopChain (
    .clk(clk),
    .reset(reset),
    .go(s_reg.totStopGo),
    .cancel(haltChains),
    .useExt(s_reg.ctrl.totStopSrc == mac_pkg::TSTOP_EXT),
    .fallEdge(s_reg.ctrl.totStopFall),
    .extRise(extRise),
    .extFall(extFall),
    .delayMode(totStopMode),
    .delayCycles(gateCyc),
    .eventTarget(s_reg.stopCount),
    .eventPulse(1'b0),
    .fire(totStopFire)
  );
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign startArm = tiStartFire;
  assign stopArm = tiStopFire;
  assign totalizeGate = s_reg.gate;
  assign resultValid = s_reg.valid;
  assign measureBusy = s_reg.busy;
endmodule
`default_nettype wire

// [logic/mac_pkg.sv]
`default_nettype none
package mac_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS = 100;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned DCW = 40;
  localparam int unsigned ECW = 27;
  localparam int unsigned TW = 24;
  localparam int unsigned GW = 20;
  localparam int unsigned EVT_MIN = 1;
  localparam int unsigned EVT_MAX = 99999999;
  localparam int unsigned TICK_MIN = 1;
  localparam int unsigned TICK_MAX = 9999999;
  localparam int unsigned LONG_MIN_MS = 1000;
  localparam int unsigned LONG_MAX_MS = 10000;
  localparam int unsigned GATE_MIN_MS = 1;
  localparam int unsigned GATE_MAX_MS = 1000000;
  localparam logic [ECW-1:0] RST_EVT = 27'h0000001;
  localparam logic [TW-1:0] RST_TICKS = 24'h000001;
  localparam logic [GW-1:0] RST_GATE_MS = 20'h00064;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_START_COUNT = 8'h08;
  localparam logic [7:0] OFS_START_TIME = 8'h0c;
  localparam logic [7:0] OFS_STOP_COUNT = 8'h10;
  localparam logic [7:0] OFS_STOP_TIME = 8'h14;
  localparam logic [7:0] OFS_GATE_TIME = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam int unsigned CMD_INITIATE = 0;
  localparam int unsigned CMD_ABORT = 1;
  localparam int unsigned CMD_CFG_RESET = 2;
  localparam int unsigned STOP_LONG_BIT = 31;
  localparam int unsigned CTRL_W = 15;
  localparam int unsigned STATUS_W = 6;
  typedef enum logic [1:0] {DLY_NONE, DLY_TIME, DLY_EVENT} mac_delay_t;
  typedef enum logic [1:0] {FN_INTERVAL, FN_EDGE_TYPE, FN_TOTALIZE} mac_func_t;
  typedef enum logic [1:0] {TSTOP_NOW, TSTOP_EXT, TSTOP_TIMED} mac_tstop_t;
  typedef enum logic [1:0] {CH_IDLE, CH_EDGE, CH_TIME, CH_EVENT} mac_chain_state_t;
  typedef struct packed {
    logic totStopFall;
    mac_tstop_t totStopSrc;
    logic totStartFall;
    logic totStartExt;
    mac_func_t func;
    mac_delay_t stopDelay;
    logic stopFall;
    logic stopExt;
    mac_delay_t startDelay;
    logic startFall;
    logic startExt;
  } mac_ctrl_t;
  localparam mac_ctrl_t CTRL_RESET = '{
    totStopFall: 1'b1,
    totStopSrc: TSTOP_TIMED,
    totStartFall: 1'b0,
    totStartExt: 1'b0,
    func: FN_INTERVAL,
    stopDelay: DLY_NONE,
    stopFall: 1'b0,
    stopExt: 1'b0,
    startDelay: DLY_NONE,
    startFall: 1'b0,
    startExt: 1'b0
  };
endpackage
`default_nettype wire

// [logic/mac_arm_chain.sv]
`default_nettype none
module mac_arm_chain #(
  parameter int unsigned DCW = mac_pkg::DCW,
  parameter int unsigned ECW = mac_pkg::ECW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic cancel,
  input wire logic useExt,
  input wire logic fallEdge,
  input wire logic extRise,
  input wire logic extFall,
  input wire mac_pkg::mac_delay_t delayMode,
  input wire logic [DCW-1:0] delayCycles,
  input wire logic [ECW-1:0] eventTarget,
  input wire logic eventPulse,
  output logic fire
);
  typedef struct packed {
    mac_pkg::mac_chain_state_t state;
    logic [DCW-1:0] cnt;
    logic fire;
  } mac_chain_t;
  mac_chain_t s_reg;
  mac_chain_t s_next;
  logic enter;
  always_comb begin
    s_next = s_reg;
    s_next.fire = 1'b0;
    enter = 1'b0;
    case (s_reg.state)
      mac_pkg::CH_IDLE: begin
        if (go && !useExt) begin
          enter = 1'b1;
        end else if (go) begin
          s_next.state = mac_pkg::CH_EDGE;
        end
      end
      mac_pkg::CH_EDGE: begin
        if (fallEdge ? extFall : extRise) begin
          enter = 1'b1;
        end
      end
      mac_pkg::CH_TIME: begin
        if (s_reg.cnt <= DCW'(1)) begin
          s_next.fire = 1'b1;
          s_next.state = mac_pkg::CH_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - DCW'(1);
        end
      end
      mac_pkg::CH_EVENT: begin
        if (eventPulse && s_reg.cnt <= DCW'(1)) begin
          s_next.fire = 1'b1;
          s_next.state = mac_pkg::CH_IDLE;
        end else if (eventPulse) begin
          s_next.cnt = s_reg.cnt - DCW'(1);
        end
      end
      default: s_next.state = mac_pkg::CH_IDLE;
    endcase
    // inner layer runs only once the outer layer is satisfied
    if (enter) begin
      case (delayMode)
        mac_pkg::DLY_TIME: begin
          s_next.state = mac_pkg::CH_TIME;
          s_next.cnt = delayCycles;
        end
        mac_pkg::DLY_EVENT: begin
          s_next.state = mac_pkg::CH_EVENT;
          s_next.cnt = {{(DCW-ECW){1'b0}}, eventTarget};
        end
        default: begin
          s_next.state = mac_pkg::CH_IDLE;
          s_next.fire = 1'b1;
        end
      endcase
    end
    if (cancel) begin
      s_next.state = mac_pkg::CH_IDLE;
      s_next.fire = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{state: mac_pkg::CH_IDLE, cnt: '0, fire: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign fire = s_reg.fire;
endmodule
`default_nettype wire

// [testbench/mac_asserts.sv]
`default_nettype none
module mac_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic startArm,
  input wire logic stopArm,
  input wire logic totalizeGate,
  input wire logic resultValid,
  input wire logic measureBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_one_wait;
    s_access |=> s_answer;
  endproperty
  property p_idle_quiet;
    !(psel && penable) |=> !pready;
  endproperty
  property p_start_pulse;
    startArm |=> !startArm && !stopArm;
  endproperty
  property p_stop_pulse;
    stopArm |=> !stopArm;
  endproperty
  property p_arm_busy;
    startArm || stopArm |-> measureBusy;
  endproperty
  property p_launch;
    $rose(measureBusy) |-> !startArm && !stopArm;
  endproperty
  property p_result_held;
    resultValid |-> !totalizeGate;
  endproperty
  property p_result_after;
    $rose(resultValid) |-> $past(totalizeGate) || $past(totalizeGate, 2);
  endproperty
  property p_reset_quiet;
    $fell(reset) |-> !pready && !startArm && !stopArm && !totalizeGate && !resultValid && !measureBusy;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not a single cycle after access");
  a_idle_quiet: assert property (p_idle_quiet) else $error("pready without access");
  a_start_pulse: assert property (p_start_pulse) else $error("start arm too long or stop too soon");
  a_stop_pulse: assert property (p_stop_pulse) else $error("stop arm longer than one cycle");
  a_arm_busy: assert property (p_arm_busy) else $error("arm while idle");
  a_launch: assert property (p_launch) else $error("arm in the launch cycle");
  a_result_held: assert property (p_result_held) else $error("result valid while gate open");
  a_result_after: assert property (p_result_after) else $error("result without gate close");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule
bind mac_measurement_arming_control mac_asserts u_asserts (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .startArm(startArm), .stopArm(stopArm),
  .totalizeGate(totalizeGate), .resultValid(resultValid), .measureBusy(measureBusy));
`default_nettype wire

// [testbench/mac_arm_source.sv]
`default_nettype none
module mac_arm_source (
  input wire logic clk,
  output logic extArm,
  output logic startChannelEvent,
  output logic stopChannelEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    extArm = 1'b0;
    startChannelEvent = 1'b0;
    stopChannelEvent = 1'b0;
  end
  task automatic setExt(input logic v, input int n);
    @(posedge clk);
    extArm <= v;
    repeat (n) @(posedge clk);
  endtask
  // each level held 4 cycles so the two-flop synchroniser sees every edge
  task automatic events(input logic onStop, input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk);
      startChannelEvent <= !onStop;
      stopChannelEvent <= onStop;
      repeat (4) @(posedge clk);
      startChannelEvent <= 1'b0;
      stopChannelEvent <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// [testbench/mac_measurement_arming_control_tb.sv]
`default_nettype none
module mac_measurement_arming_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [31:0] data; logic err;} mac_note_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, extArm, startEvt, stopEvt, startArm, stopArm, totalizeGate, resultValid, measureBusy;
  mac_note_t noteQ[$];
  mac_note_t nt;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int readyCyc = 0, startCyc = 0, stopCyc = 0, nStart = 0, nStop = 0, gateN = 0, s0 = 0;
  logic [31:0] rng = 32'he1bb;
  logic [31:0] v;
  logic [31:0] rstVal [8] = '{32'h6000, 32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h64, 32'h0};
  logic [40:0] wt [13] = '{{8'h08, 32'h0, 1'b1}, {8'h08, 32'h5f5e100, 1'b1}, {8'h08, 32'h5f5e0ff, 1'b0},
    {8'h10, 32'h0, 1'b1}, {8'h10, 32'h5f5e0ff, 1'b0}, {8'h0c, 32'h989680, 1'b1}, {8'h0c, 32'h98967f, 1'b0},
    {8'h14, 32'h800003e7, 1'b1}, {8'h14, 32'h80002710, 1'b0}, {8'h14, 32'h80002711, 1'b1},
    {8'h00, 32'h600c, 1'b1}, {8'h1c, 32'h0, 1'b1}, {8'h20, 32'h0, 1'b1}};
  mac_measurement_arming_control #(.CYC_PER_MS(10)) dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extArm(extArm), .startChannelEvent(startEvt), .stopChannelEvent(stopEvt),
    .startArm(startArm), .stopArm(stopArm), .totalizeGate(totalizeGate), .resultValid(resultValid),
    .measureBusy(measureBusy));
  mac_arm_source part (.clk(clk), .extArm(extArm), .startChannelEvent(startEvt), .stopChannelEvent(stopEvt));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ck(input string what, input logic exp, input logic got);
    check(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one idle edge before each setup keeps a driver from assigning twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    n = 0;
    @(posedge clk);
    noteQ.push_back('{w, d, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 1'b0);
  endtask
  task automatic cmd(input int b);
    wr(mac_pkg::OFS_CMD, 32'h1 << b, 1'b0);
  endtask
  task automatic waitIdle(input int bound);
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (measureBusy !== 1'b0 && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (n >= bound) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic run(input logic [31:0] ctrl, input int bound);
    wr(8'h00, ctrl, 1'b0);
    cmd(mac_pkg::CMD_INITIATE);
    waitIdle(bound);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (totalizeGate === 1'b1) gateN++;
    if (startArm === 1'b1) begin
      startCyc = cyc;
      nStart++;
    end
    if (stopArm === 1'b1) begin
      stopCyc = cyc;
      nStop++;
    end
    if (pready === 1'b1) begin
      readyCyc = cyc;
      if (noteQ.size() == 0) check("unexpected pready", 32'h0, 32'h1);
      else begin
        nt = noteQ.pop_front();
        if (!nt.wr && !nt.err) check("prdata", nt.data, prdata);
        check("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), rstVal[i]);
    for (int i = 0; i < 13; i++) wr(wt[i][40:33], wt[i][32:1], wt[i][0]);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    rd(8'h08, 32'h5f5e0ff);
    rd(8'h10, 32'h5f5e0ff);
    rd(8'h0c, 32'h98967f);
    rd(8'h14, 32'h80002710);
    rd(8'h00, 32'h6000);
    repeat (4) begin
      rng = xs(rng);
      v = rng % 32'h5f5e0ff + 32'h1;
      wr(8'h08, v, 1'b0);
      rd(8'h08, v);
    end
    run(32'h6000, 50);
    check("start latency", 32'h2, startCyc - readyCyc);
    check("stop gap", 32'h2, stopCyc - startCyc);
    wr(8'h08, 32'h3, 1'b0);
    wr(8'h10, 32'h2, 1'b0);
    wr(8'h00, 32'h609b, 1'b0);
    cmd(mac_pkg::CMD_INITIATE);
    s0 = nStart;
    part.setExt(1'b1, 10);
    part.events(1'b0, 3);
    check("start before fall", s0, nStart);
    part.setExt(1'b0, 10);
    part.events(1'b0, 2);
    check("start before count", s0, nStart);
    part.events(1'b0, 1);
    check("start after count", s0 + 1, nStart);
    s0 = nStop;
    part.events(1'b1, 2);
    check("stop before edge", s0, nStop);
    part.setExt(1'b1, 10);
    part.events(1'b1, 1);
    check("stop before count", s0, nStop);
    part.events(1'b1, 1);
    waitIdle(100);
    check("stop after count", s0 + 1, nStop);
    wr(8'h0c, 32'h4, 1'b0);
    wr(8'h14, 32'h800003e8, 1'b0);
    run(32'h6044, 12000);
    check("start timed", 32'h1, {31'h0, (startCyc - readyCyc) inside {[50:56]}});
    check("stop timed", 32'h1, {31'h0, (stopCyc - startCyc) inside {[10000:10006]}});
    wr(8'h08, 32'h3, 1'b0);
    run(32'h6188, 60);
    check("edge start", 32'h2, startCyc - readyCyc);
    check("edge stop", 32'h2, stopCyc - startCyc);
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, i ? 32'h4600 : 32'h5200, 1'b0);
      cmd(mac_pkg::CMD_INITIATE);
      repeat (4) @(posedge clk);
      ck("refused pair", 1'b0, measureBusy);
    end
    rd(8'h1c, 32'h26);
    wr(8'h00, 32'h4200, 1'b0);
    cmd(mac_pkg::CMD_INITIATE);
    repeat (20) @(posedge clk);
    ck("free gate", 1'b1, totalizeGate);
    ck("early result", 1'b0, resultValid);
    cmd(mac_pkg::CMD_ABORT);
    repeat (3) @(posedge clk);
    ck("aborted gate", 1'b0, totalizeGate);
    ck("final result", 1'b1, resultValid);
    wr(8'h18, 32'h2, 1'b0);
    wr(8'h00, 32'h6200, 1'b0);
    cmd(mac_pkg::CMD_INITIATE);
    gateN = 0;
    waitIdle(200);
    check("gate length", 32'h1, {31'h0, gateN inside {[20:23]}});
    ck("timed result", 1'b1, resultValid);
    part.setExt(1'b0, 10);
    wr(8'h00, 32'h5600, 1'b0);
    cmd(mac_pkg::CMD_INITIATE);
    repeat (10) @(posedge clk);
    ck("gate before edge", 1'b0, totalizeGate);
    part.setExt(1'b1, 10);
    ck("gate on rise", 1'b1, totalizeGate);
    part.setExt(1'b0, 10);
    ck("gate on fall", 1'b0, totalizeGate);
    cmd(mac_pkg::CMD_CFG_RESET);
    rd(8'h00, 32'h6000);
    rd(8'h14, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
